// File: brownout_consts.vh
`ifndef BROWNOUT_CONSTS_VH
`define BROWNOUT_CONSTS_VH
// ==========================================
// register offsets
`define OFS_POR_DISABLE   8'h60
`define OFS_BOD_CONTROL   8'h64
`define OFS_BOD_STATUS    8'h68
`define OFS_VREF_CONTROL  8'h6C
// ==========================================
// reset values and keys
`define POR_DISABLE_KEY   16'h5AA5
`define POR_DISABLE_RST   16'h0000
`define VREF_CONTROL_RST  32'h00000700
`define VREF_CONTROL_MASK 32'h00000F1F
// ==========================================
// control field positions
`define CTL_HIGH_TRIM_HI  23
`define CTL_HIGH_TRIM_LO  20
`define CTL_MID_TRIM_HI   19
`define CTL_MID_TRIM_LO   16
`define CTL_LOW_TRIM_HI   15
`define CTL_LOW_TRIM_LO   12
`define CTL_IRQ_EN_HI     10
`define CTL_IRQ_EN_LO     8
`define CTL_RST_EN_HI     6
`define CTL_RST_EN_LO     4
`define CTL_HIGH_DET_EN   2
`define CTL_MID_DET_EN    1
`define CTL_LOW_DET_EN    0
`define TRIM_RST          4'h0
// ==========================================
// status field positions
`define STS_LIVE_HI       10
`define STS_LIVE_LO       8
`define STS_RISE_HI       6
`define STS_RISE_LO       4
`define STS_DROP_HI       3
`define STS_DROP_LO       1
`define STS_EVENT         0
// user config word zero bit positions
`define CFG0_BOD_HI       20
`define CFG0_BOD_LO       19
`endif

// File: brownout_por_control.v
`timescale 1ns/1ps
`default_nettype none
`include "brownout_consts.vh"
// Notes on behaviour
// - key 5AA5 suppresses power-on reset
// - other chip resets clear the key
// - protected fields ignore writes while locked
// - three 4-bit trims drive the detectors
// - per-level interrupt enables bits 10..8
// - per-level reset enables bits 6..4
// - reset enables, low detector from config
// - low reset forced on when detector off
// - bit 2 enables the high detector
// - mid enable clear only in power-down
// - low detector always on outside power-down
// - low enable reads actual detector activity
// - live status mirrors comparator outputs
// - sticky rise flags, write one clears
// - sticky drop flags, write one clears
// - event flag on enabled crossing, w1c
module brownout_por_control (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_other_chip_reset,
    input  wire        i_unlocked,
    input  wire        i_power_down,
    input  wire [1:0]  i_cfg0_bod,
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    input  wire [2:0]  i_det_above,
    input  wire        i_por_raw,
    output reg  [31:0] o_rdata,
    output wire        o_por_reset,
    output wire [3:0]  o_high_trim,
    output wire [3:0]  o_mid_trim,
    output wire [3:0]  o_low_trim,
    output wire [2:0]  o_det_on,
    output wire        o_bod_reset,
    output wire        o_irq
);
    reg  [15:0] power_on_reset_disable_key;
    reg  [3:0]  high_level_threshold_trim;
    reg  [3:0]  mid_level_threshold_trim;
    reg  [3:0]  low_level_threshold_trim;
    reg  [2:0]  irq_enable;
    reg  [2:0]  reset_enable;
    reg         high_level_detector_enable;
    reg         mid_level_detector_enable;
    reg         low_level_detector_enable;
    reg  [2:0]  rise_flag;
    reg  [2:0]  drop_flag;
    reg         brownout_event_flag;
    reg  [31:0] vref_control;
    reg         cfg_loaded;
    reg         por_meta;
    reg         por_sync;
    wire [2:0]  live;
    wire [2:0]  rise_evt;
    wire [2:0]  fall_evt;
    wire [2:0]  det_active;
    wire [2:0]  reset_gate;
    wire        wr_por;
    wire        wr_ctl;
    wire        wr_sts;
    wire        wr_vref;
    wire [2:0]  clr_rise;
    wire [2:0]  clr_drop;
    wire        clr_event;
    wire        any_crossing;
    reg  [31:0] next_rdata;

    // ==========================================
    // detector synchronisers, one per level
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_sync
            level_edge_sync u_sync (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_async (i_det_above[g]),
                .o_level (live[g]),
                .o_rise  (rise_evt[g]),
                .o_fall  (fall_evt[g])
            );
        end
    endgenerate

    // ==========================================
    // write decode
    assign wr_por  = i_wr & i_unlocked & (i_addr == `OFS_POR_DISABLE);
    assign wr_ctl  = i_wr & i_unlocked & (i_addr == `OFS_BOD_CONTROL);
    assign wr_vref = i_wr & i_unlocked & (i_addr == `OFS_VREF_CONTROL);
    // status flags are plain write-one-clear, not protected
    assign wr_sts  = i_wr & (i_addr == `OFS_BOD_STATUS);
    assign clr_rise  = wr_sts ? i_wdata[`STS_RISE_HI:`STS_RISE_LO] : 3'h0;
    assign clr_drop  = wr_sts ? i_wdata[`STS_DROP_HI:`STS_DROP_LO] : 3'h0;
    assign clr_event = wr_sts & i_wdata[`STS_EVENT];

    // ==========================================
    // power-on reset disable key
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            power_on_reset_disable_key <= `POR_DISABLE_RST;
        end else if (i_other_chip_reset) begin
            power_on_reset_disable_key <= `POR_DISABLE_RST;
        end else if (wr_por) begin
            power_on_reset_disable_key <= i_wdata[15:0];
        end
    end

    // raw power-on pulse comes from the analog domain
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            por_meta <= 1'b0;
            por_sync <= 1'b0;
        end else begin
            por_meta <= i_por_raw;
            por_sync <= por_meta;
        end
    end
    assign o_por_reset = por_sync &
        (power_on_reset_disable_key != `POR_DISABLE_KEY);

    // ==========================================
    // brown-out control
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            high_level_threshold_trim  <= `TRIM_RST;
            mid_level_threshold_trim   <= `TRIM_RST;
            low_level_threshold_trim   <= `TRIM_RST;
            irq_enable                 <= 3'h0;
            reset_enable               <= 3'h0;
            high_level_detector_enable <= 1'b0;
            mid_level_detector_enable  <= 1'b1;
            low_level_detector_enable  <= 1'b0;
            cfg_loaded                 <= 1'b0;
        end else begin
            if (!cfg_loaded) begin
                // strap taken by a clock edge after reset release
                cfg_loaded   <= 1'b1;
                reset_enable <= {3{i_cfg0_bod[1]}};
                low_level_detector_enable <= i_cfg0_bod[0];
            end else if (wr_ctl) begin
                high_level_threshold_trim <=
                    i_wdata[`CTL_HIGH_TRIM_HI:`CTL_HIGH_TRIM_LO];
                mid_level_threshold_trim <=
                    i_wdata[`CTL_MID_TRIM_HI:`CTL_MID_TRIM_LO];
                low_level_threshold_trim <=
                    i_wdata[`CTL_LOW_TRIM_HI:`CTL_LOW_TRIM_LO];
                irq_enable <= i_wdata[`CTL_IRQ_EN_HI:`CTL_IRQ_EN_LO];
                reset_enable <= i_wdata[`CTL_RST_EN_HI:`CTL_RST_EN_LO];
                high_level_detector_enable <=
                    i_wdata[`CTL_HIGH_DET_EN];
                low_level_detector_enable <= i_wdata[`CTL_LOW_DET_EN];
            end
            // outside power-down hardware forces the mid enable back on
            if (!i_power_down) begin
                mid_level_detector_enable <= 1'b1;
            end else if (cfg_loaded && wr_ctl) begin
                mid_level_detector_enable <= i_wdata[`CTL_MID_DET_EN];
            end
        end
    end

    assign o_high_trim = high_level_threshold_trim;
    assign o_mid_trim  = mid_level_threshold_trim;
    assign o_low_trim  = low_level_threshold_trim;

    assign det_active[2] = high_level_detector_enable;
    assign det_active[1] = mid_level_detector_enable;
    assign det_active[0] = ~i_power_down | low_level_detector_enable;
    assign o_det_on = det_active;

    // ==========================================
    // reset requests
    assign reset_gate[2] = reset_enable[2];
    assign reset_gate[1] = reset_enable[1];
    assign reset_gate[0] = ~low_level_detector_enable |
                           reset_enable[0];
    // level request while below an armed threshold, not just at the edge,
    // so the reset stays asserted for as long as the supply is low
    assign o_bod_reset = |(reset_gate & det_active & ~live & {3{cfg_loaded}});

    // ==========================================
    // sticky flags, set wins over clear
    assign any_crossing = |((rise_evt | fall_evt) & irq_enable & det_active);
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rise_flag           <= 3'h0;
            drop_flag           <= 3'h0;
            brownout_event_flag <= 1'b0;
        end else begin
            rise_flag <= (rise_flag & ~clr_rise) | rise_evt;
            drop_flag <= (drop_flag & ~clr_drop) | fall_evt;
            brownout_event_flag <= (brownout_event_flag & ~clr_event) |
                                   any_crossing;
        end
    end
    assign o_irq = brownout_event_flag;

    // ==========================================
    // reference control, storage only
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            vref_control <= `VREF_CONTROL_RST;
        end else if (wr_vref) begin
            vref_control <= i_wdata & `VREF_CONTROL_MASK;
        end
    end

    // ==========================================
    // read path, data one cycle after the strobe
    always @* begin
        next_rdata = 32'h00000000;
        case (i_addr)
            `OFS_POR_DISABLE: begin
                next_rdata[15:0] = power_on_reset_disable_key;
            end
            `OFS_BOD_CONTROL: begin
                next_rdata[`CTL_HIGH_TRIM_HI:`CTL_HIGH_TRIM_LO] =
                    high_level_threshold_trim;
                next_rdata[`CTL_MID_TRIM_HI:`CTL_MID_TRIM_LO] =
                    mid_level_threshold_trim;
                next_rdata[`CTL_LOW_TRIM_HI:`CTL_LOW_TRIM_LO] =
                    low_level_threshold_trim;
                next_rdata[`CTL_IRQ_EN_HI:`CTL_IRQ_EN_LO] = irq_enable;
                next_rdata[`CTL_RST_EN_HI:`CTL_RST_EN_LO] = reset_enable;
                next_rdata[`CTL_HIGH_DET_EN] = high_level_detector_enable;
                next_rdata[`CTL_MID_DET_EN]  = mid_level_detector_enable;
                next_rdata[`CTL_LOW_DET_EN]  = det_active[0];
            end
            `OFS_BOD_STATUS: begin
                next_rdata[`STS_LIVE_HI:`STS_LIVE_LO] = live;
                next_rdata[`STS_RISE_HI:`STS_RISE_LO] = rise_flag;
                next_rdata[`STS_DROP_HI:`STS_DROP_LO] = drop_flag;
                next_rdata[`STS_EVENT] = brownout_event_flag;
            end
            `OFS_VREF_CONTROL: begin
                next_rdata = vref_control;
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// File: brownout_por_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "brownout_consts.vh"
// ==========================================
// port checks
module brownout_por_control_chk (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_unlocked,
    input wire logic        i_power_down,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [2:0]  i_det_above,
    input wire logic        i_por_raw,
    input wire logic [31:0] o_rdata,
    input wire logic        o_por_reset,
    input wire logic [3:0]  o_high_trim,
    input wire logic [3:0]  o_mid_trim,
    input wire logic [3:0]  o_low_trim,
    input wire logic [2:0]  o_det_on,
    input wire logic        o_bod_reset,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire ctl_wr = i_wr && i_addr == `OFS_BOD_CONTROL;
    wire clr_ev = i_wr && i_addr == `OFS_BOD_STATUS && i_wdata[0];
    wire sts_rd = i_rd && i_addr == `OFS_BOD_STATUS;
    logic [2:0] last_det;
    logic [2:0] calm;
    wire settled = i_det_above == last_det;
    // inputs are async: count quiet edges until the sync pipe is flushed
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            last_det <= 3'h0;
            calm     <= 3'h0;
        end else begin
            last_det <= i_det_above;
            if (!settled)
                calm <= 3'h0;
            else if (calm != 3'h7)
                calm <= calm + 3'h1;
        end
    end
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero");
    live_read_a: assert property (sts_rd && calm >= 3'h3 && settled &&
        o_det_on == 3'h7 |=> o_rdata[10:8] == $past(i_det_above))
        else $error("live status wrong");
    irq_clear_a: assert property (clr_ev && calm >= 3'h4 && settled
        |=> !o_irq) else $error("event flag not cleared");
    irq_hold_a: assert property (o_irq && !clr_ev |=> o_irq)
        else $error("event flag lost");
    trim_write_a: assert property (ctl_wr && i_unlocked && !$past(i_rst)
        |=> {o_high_trim, o_mid_trim, o_low_trim} == $past(i_wdata[23:12]))
        else $error("trim not written");
    trim_lock_a: assert property (ctl_wr && !i_unlocked
        |=> $stable({o_high_trim, o_mid_trim, o_low_trim}))
        else $error("locked write took effect");
    mid_on_a: assert property (!i_power_down |=> o_det_on[1])
        else $error("mid detector off");
    low_on_a: assert property (!i_power_down |-> o_det_on[0])
        else $error("low detector off");
    por_quiet_a: assert property ((!i_por_raw)[*4] |-> !o_por_reset)
        else $error("power-on reset without request");
    bod_quiet_a: assert property ((i_det_above == 3'h7)[*4] |->
        !o_bod_reset) else $error("reset with supply above");
    cover property (o_irq);
    cover property (o_bod_reset);
    cover property (o_por_reset);
endmodule
`default_nettype wire

// File: comparator_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// analog comparators and raw power-on reset
module comparator_model #(
    parameter int POR_MV = 1600
) (
    input  wire logic [11:0] i_supply_mv,
    input  wire logic [3:0]  i_high_trim,
    input  wire logic [3:0]  i_mid_trim,
    input  wire logic [3:0]  i_low_trim,
    input  wire logic [2:0]  i_det_on,
    output logic [2:0]       o_det_above,
    output logic             o_por_raw
);
    // a switched-off comparator idles high so it makes no crossing
    always @* begin
        o_det_above[2] = !i_det_on[2] ||
            i_supply_mv > 2500 + 10 * i_high_trim;
        o_det_above[1] = !i_det_on[1] ||
            i_supply_mv > 2000 + 10 * i_mid_trim;
        o_det_above[0] = !i_det_on[0] ||
            i_supply_mv > 1700 + 10 * i_low_trim;
        o_por_raw = i_supply_mv < POR_MV;
    end
endmodule
`default_nettype wire

// File: level_edge_sync.v
`timescale 1ns/1ps
`default_nettype none
module level_edge_sync (
    input  wire i_clk,
    input  wire i_rst,
    input  wire i_async,
    output wire o_level,
    output wire o_rise,
    output wire o_fall
);
    reg       meta;
    reg       sync;
    reg       prev;
    reg [1:0] settle;
    wire      edge_ok;

    // ==========================================
    // two-stage synchroniser, edge detect on the second stage only
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta   <= 1'b0;
            sync   <= 1'b0;
            prev   <= 1'b0;
            settle <= 2'h0;
        end else begin
            meta <= i_async;
            sync <= meta;
            prev <= sync;
            if (settle != 2'h3) begin
                settle <= settle + 2'h1;
            end
        end
    end

    // the pipe resets low while a healthy supply idles high: hold off
    // edges until prev carries a real sample, else every reset would
    // leave a false rise flag behind
    assign edge_ok = (settle == 2'h3);
    assign o_level = sync;
    assign o_rise  = edge_ok & sync & ~prev;
    assign o_fall  = edge_ok & ~sync & prev;
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "brownout_consts.vh"
// ==========================================
// bench
module tb;
    logic        clk = 1'b0;
    logic        rst, other, unl, pd, wr, rd, por_raw, por_rst, bod_rst, irq;
    logic [1:0]  cfg;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [11:0] supply;
    logic [3:0]  ht, mt, lt;
    logic [2:0]  det, det_on, det_m;
    int          err_count = 0, total_checks = 0, cyc = 0;
    int          seed, ctl_m, sts_m, low_en, d;
    int          sups [4] = '{2300, 1900, 1500, 3000};
    int          ctls [2] = '{32'h747, 32'h002};
    always #10 clk = ~clk;
    brownout_por_control uut (.i_clk(clk), .i_rst(rst),
        .i_other_chip_reset(other), .i_unlocked(unl), .i_power_down(pd),
        .i_cfg0_bod(cfg), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .i_det_above(det), .i_por_raw(por_raw), .o_rdata(rdata),
        .o_por_reset(por_rst), .o_high_trim(ht), .o_mid_trim(mt),
        .o_low_trim(lt), .o_det_on(det_on), .o_bod_reset(bod_rst),
        .o_irq(irq));
    comparator_model far (.i_supply_mv(supply), .i_high_trim(ht),
        .i_mid_trim(mt), .i_low_trim(lt), .i_det_on(det_on),
        .o_det_above(det), .o_por_raw(por_raw));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input int v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input int e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
        @(posedge clk);
    endtask
    function automatic logic [2:0] mdet(input int mv);
        mdet[2] = !ctl_m[2] || mv > 2500 + 10 * ctl_m[23:20];
        mdet[1] = mv > 2000 + 10 * ctl_m[19:16];
        mdet[0] = mv > 1700 + 10 * ctl_m[15:12];
    endfunction
    function automatic logic bod_exp();
        logic [2:0] g;
        g = {ctl_m[6], ctl_m[5], low_en == 0 || ctl_m[4]};
        return |(g & ~det_m);
    endfunction
    // the bench keeps its own sticky flags from each supply step
    task automatic supply_to(input int mv);
        logic [2:0] n;
        n = mdet(mv);
        sts_m = sts_m & 32'h7F | n << 8 | (n & ~det_m) << 4 |
                (det_m & ~n) << 1;
        if (((n ^ det_m) & ctl_m[10:8]) != 3'h0)
            sts_m = sts_m | 1;
        det_m = n;
        supply <= mv[11:0];
        step(6);
    endtask
    task automatic final_report;
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            final_report;
        end
    end
    initial begin
        seed = 32'h145826A6;
        {rst, other, unl, pd, wr, rd} <= 6'h20;
        addr <= 8'h00;
        wdata <= 32'h0;
        supply <= 12'hBB8;
        cfg <= 2'($random(seed));
        step(8);
        rst <= 1'b0;
        step(8);
        low_en = cfg[0];
        ctl_m = {cfg[1], cfg[1], cfg[1]} << 4 | 3;
        det_m = 3'h7;
        wr_reg(`OFS_BOD_STATUS, 32'h7F);
        sts_m = 32'h700;
        rd_chk(`OFS_BOD_STATUS, sts_m);
        rd_chk(`OFS_POR_DISABLE, 32'h0);
        rd_chk(`OFS_BOD_CONTROL, ctl_m);
        wr_reg(`OFS_BOD_CONTROL, $random(seed));
        wr_reg(`OFS_VREF_CONTROL, $random(seed));
        rd_chk(`OFS_BOD_CONTROL, ctl_m);
        rd_chk(`OFS_VREF_CONTROL, `VREF_CONTROL_RST);
        rd_chk(8'h70, 32'h0);
        unl <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            wr_reg(`OFS_BOD_CONTROL, d);
            ctl_m = d & 32'hFFF774 | 3;
            low_en = d & 1;
            rd_chk(`OFS_BOD_CONTROL, ctl_m);
            chk({ht, mt, lt}, ctl_m[23:12]);
            chk(det_on, {ctl_m[2], 2'b11});
        end
        wr_reg(`OFS_VREF_CONTROL, d);
        rd_chk(`OFS_VREF_CONTROL, d & `VREF_CONTROL_MASK);
        for (int c = 0; c < 2; c++) begin
            wr_reg(`OFS_BOD_CONTROL, ctls[c]);
            ctl_m = ctls[c] | 3;
            low_en = ctls[c] & 1;
            det_m = mdet(3000);
            wr_reg(`OFS_BOD_STATUS, 32'h7F);
            sts_m = sts_m & 32'h700;
            foreach (sups[s]) begin
                supply_to(sups[s]);
                @(negedge clk);
                chk(irq, sts_m[0]);
                chk(bod_rst, bod_exp());
                @(posedge clk);
                rd_chk(`OFS_BOD_STATUS, sts_m);
            end
        end
        pd <= 1'b1;
        wr_reg(`OFS_BOD_CONTROL, 32'h0);
        rd_chk(`OFS_BOD_CONTROL, 32'h0);
        chk(det_on, 3'h0);
        pd <= 1'b0;
        step(2);
        rd_chk(`OFS_BOD_CONTROL, 32'h3);
        supply_to(1500);
        wr_reg(`OFS_POR_DISABLE, 32'h5AA5);
        step(4);
        chk(por_rst, 1'b0);
        wr_reg(`OFS_POR_DISABLE, 32'h5AA4);
        step(4);
        chk(por_rst, 1'b1);
        wr_reg(`OFS_POR_DISABLE, 32'h5AA5);
        other <= 1'b1;
        step(1);
        other <= 1'b0;
        step(4);
        chk(por_rst, 1'b1);
        rd_chk(`OFS_POR_DISABLE, 32'h0);
        final_report;
    end
endmodule
bind brownout_por_control brownout_por_control_chk chk (.*);
`default_nettype wire
